//--- src/lin_uart_status_flags.v
`timescale 1ns/1ps
`default_nettype none
`include "lin_uart_status_regs.vh"
module lin_uart_status_flags #(
  parameter CMP_WIDTH = 16
) (
  input wire ref_clk_i, // 20 MHz module clock
  input wire rst_n_i, // Async reset, active low
  input wire ce_i, // Clock enable, freezes state when low
  input wire [7:0] addr_i, // Register byte address
  input wire [15:0] wdata_i, // Write data
  input wire wr_i, // Write strobe
  input wire rd_i, // Read strobe
  output reg [15:0] rdata_o, // Read data, cycle after strobe
  input wire auto_frame_start_i, // Link engine started a frame (pulse)
  input wire tx_done_i, // Transmit processing complete (pulse)
  input wire rx_done_i, // Receive processing complete (pulse)
  input wire tx_last_sent_i, // Last transmit data sent (pulse)
  input wire rx_last_stored_i, // Last expected data stored (pulse)
  input wire rx_byte_i, // Received byte arrives (pulse)
  input wire rx_buf_full_i, // Receive buffer has no room (level)
  input wire csum_mismatch_i, // Checksum compare failed (pulse)
  input wire rx_line_i, // Serial receive pin
  output reg rx_store_o, // Store received byte into buffer
  output reg [15:0] status_o, // Live status high register
  output reg module_enable_o, // Module enable bit
  output reg [1:0] mode_o, // Operating mode
  output reg status_irq_o, // Status interrupt request (pulse)
  output reg irq_o, // Level interrupt, unmasked pending
  output reg rx_line_o // Synchronised serial receive level
);
  reg [15:0] ctl_r;
  reg [CMP_WIDTH-1:0] cmp_r;
  reg [6:0] flags_r;
  reg [6:0] flags_nxt;
  reg [6:0] irq_stat_r;
  reg [6:0] irq_mask_r;
  reg [6:0] clr_w;
  reg [6:0] set_w;
  wire sched_match;
  wire rx_sync;
  wire ctl_wr = wr_i && (addr_i == `OFS_CONTROL);
  wire clr_wr = wr_i && (addr_i == `OFS_CLEAR);
  // A control write acts in its own cycle, so the enabling write may carry a request
  wire [15:0] ctl_eff = ctl_wr ? wdata_i : ctl_r;
  wire enable = ctl_eff[`CTL_ENABLE];
  wire [1:0] mode = ctl_eff[`CTL_MODE_LSB+1:`CTL_MODE_LSB];
  wire is_thru = (mode == `MODE_UART_THRU);
  wire is_master = (mode == `MODE_LIN_MASTER);
  wire is_lin = is_master || (mode == `MODE_LIN_SLAVE);
  wire auto_frame = ctl_eff[`CTL_AUTO_FRAME];
  wire sched_run = enable && is_master && ctl_eff[`CTL_SCHED_EN] && !auto_frame;
  wire [15:0] status_view = {flags_r, 9'h000};
  // Scheduler counter keeps running only while its flag can be produced
  sched_counter #(
    .WIDTH(CMP_WIDTH)
  ) u_sched (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .run_i(sched_run),
    .compare_i(cmp_r),
    .match_o(sched_match)
  );
  sync2 #(
    .WIDTH(1)
  ) u_rx_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .d_i(rx_line_i),
    .q_o(rx_sync)
  );
  // Flag index: 6 tx req, 5 rx req, 4 tx empty, 3 rx full, 2 ovf, 1 csum, 0 sched
  always @*
  begin
    set_w = 7'h00;
    clr_w = 7'h00;
    set_w[6] = !is_thru && ((ctl_wr && wdata_i[`CTL_TX_REQ] && wdata_i[`CTL_ENABLE])
      || (is_lin && auto_frame && auto_frame_start_i));
    set_w[5] = !is_thru && !is_master && ctl_wr && wdata_i[`CTL_RX_REQ]
      && wdata_i[`CTL_ENABLE];
    set_w[4] = !is_thru && tx_last_sent_i;
    set_w[3] = !is_thru && rx_last_stored_i;
    set_w[2] = !is_thru && !is_master && rx_byte_i && rx_buf_full_i;
    set_w[1] = is_master && ctl_eff[`CTL_AUTO_CSUM] && csum_mismatch_i;
    set_w[0] = sched_run && sched_match;
    clr_w[6] = tx_done_i;
    clr_w[5] = rx_done_i;
    if (clr_wr)
    begin
      clr_w[4] = wdata_i[`ST_TX_EMPTY];
      clr_w[3] = wdata_i[`ST_RX_FULL];
      clr_w[2] = wdata_i[`ST_RX_OVF];
      clr_w[1] = wdata_i[`ST_CSUM_ERR];
      clr_w[0] = wdata_i[`ST_SCHED];
    end
    // Set wins over a clear in the same cycle
    flags_nxt = (flags_r & ~clr_w) | set_w;
    if (!enable)
      flags_nxt = 7'h00;
  end
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctl_r <= `CONTROL_RESET;
      cmp_r <= {CMP_WIDTH{1'b0}};
      flags_r <= 7'h00;
      irq_stat_r <= 7'h00;
      irq_mask_r <= 7'h00;
      rdata_o <= 16'h0000;
      rx_store_o <= 1'b0;
      status_o <= `STATUS_RESET;
      module_enable_o <= 1'b0;
      mode_o <= 2'h0;
      status_irq_o <= 1'b0;
      irq_o <= 1'b0;
      rx_line_o <= 1'b0;
    end
    else if (ce_i)
    begin
      // Request bits 9:8 are self-clearing: all other control bits are kept
      if (ctl_wr)
        ctl_r <= {wdata_i[15:10], 2'b00, wdata_i[7:0]};
      if (wr_i && addr_i == `OFS_COMPARE)
        cmp_r <= wdata_i[CMP_WIDTH-1:0];
      flags_r <= flags_nxt;
      // Sticky irq bits; a read clears them but a new event still sets
      if (rd_i && addr_i == `OFS_IRQ_STATUS)
        irq_stat_r <= set_w & {7{enable}};
      else
        irq_stat_r <= irq_stat_r | (set_w & {7{enable}});
      if (wr_i && addr_i == `OFS_IRQ_MASK)
        irq_mask_r <= wdata_i[15:9];
      irq_o <= |(irq_stat_r & irq_mask_r);
      status_irq_o <= set_w[0] && enable;
      rx_store_o <= enable && rx_byte_i && !rx_buf_full_i;
      status_o <= {flags_nxt, 9'h000};
      module_enable_o <= enable;
      mode_o <= mode;
      rx_line_o <= rx_sync;
      rdata_o <= 16'h0000;
      if (rd_i)
      begin
        case (addr_i)
          `OFS_CONTROL: rdata_o <= ctl_r;
          // read-only view, writes have no decode
          `OFS_STATUS_HIGH: rdata_o <= status_view;
          `OFS_COMPARE: rdata_o <= cmp_r;
          `OFS_IRQ_STATUS: rdata_o <= {irq_stat_r, 9'h000};
          `OFS_IRQ_MASK: rdata_o <= {irq_mask_r, 9'h000};
          default: rdata_o <= 16'h0000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- src/lin_uart_status_regs.vh
`ifndef LIN_UART_STATUS_REGS_VH
`define LIN_UART_STATUS_REGS_VH
// Register byte offsets
`define OFS_CONTROL 8'h80
`define OFS_CLEAR 8'h84
`define OFS_STATUS_HIGH 8'h8C
`define OFS_COMPARE 8'h90
`define OFS_IRQ_STATUS 8'h94
`define OFS_IRQ_MASK 8'h98
// Control register fields
`define CTL_ENABLE 15
`define CTL_MODE_LSB 0
`define CTL_AUTO_FRAME 2
`define CTL_AUTO_CSUM 3
`define CTL_SCHED_EN 4
`define CTL_TX_REQ 8
`define CTL_RX_REQ 9
// Operating modes
`define MODE_LIN_MASTER 2'h0
`define MODE_LIN_SLAVE 2'h1
`define MODE_UART 2'h2
`define MODE_UART_THRU 2'h3
// Status bit positions
`define ST_TX_REQ 15
`define ST_RX_REQ 14
`define ST_TX_EMPTY 13
`define ST_RX_FULL 12
`define ST_RX_OVF 11
`define ST_CSUM_ERR 10
`define ST_SCHED 9
// Reset values
`define STATUS_RESET 16'h0000
`define CONTROL_RESET 16'h0000
`define COMPARE_RESET 16'h0000
`define MASK_RESET 16'h0000
`endif

//--- src/sched_counter.v
`timescale 1ns/1ps
`default_nettype none
module sched_counter #(
  parameter WIDTH = 16
) (
  input wire ref_clk_i, // Module clock
  input wire rst_n_i, // Async reset, active low
  input wire ce_i, // Clock enable
  input wire run_i, // Count while high, clears when low
  input wire [WIDTH-1:0] compare_i, // Compare value
  output reg match_o // One-cycle match pulse
);
  reg [WIDTH-1:0] count_r;
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      count_r <= {WIDTH{1'b0}};
      match_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!run_i)
      begin
        count_r <= {WIDTH{1'b0}};
        match_o <= 1'b0;
      end
      else
      begin
        // Wraps so a match repeats every 2^WIDTH cycles
        count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
        match_o <= (count_r == compare_i);
      end
    end
  end
endmodule
`default_nettype wire

//--- src/sync2.v
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter WIDTH = 1
) (
  input wire ref_clk_i, // Module clock
  input wire rst_n_i, // Async reset, active low
  input wire ce_i, // Clock enable
  input wire [WIDTH-1:0] d_i, // Asynchronous inputs
  output reg [WIDTH-1:0] q_o // Synchronised outputs
);
  reg [WIDTH-1:0] meta_r;
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_r <= {WIDTH{1'b0}};
      q_o <= {WIDTH{1'b0}};
    end
    else if (ce_i)
    begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule
`default_nettype wire

//--- tb/status_flags_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module status_flags_monitor (
  input wire logic ref_clk_i, // Clock
  input wire logic rst_n_i, // Reset, active low
  input wire logic [7:0] addr_i, // Address
  input wire logic rd_i, // Read strobe
  input wire logic wr_i, // Write strobe
  input wire logic [15:0] rdata_o, // Read data
  input wire logic rx_byte_i, // Byte arrives
  input wire logic rx_buf_full_i, // Buffer full
  input wire logic rx_store_o, // Byte stored
  input wire logic [15:0] status_o, // Status high
  input wire logic module_enable_o, // Enable
  input wire logic [1:0] mode_o, // Mode
  input wire logic status_irq_o // Match pulse
);
  default clocking dc @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_read_status: assert property (rd_i && addr_i == 8'h8C |=> rdata_o == $past(status_o))
    else $error("status read differs");
  a_disable_clear: assert property (!module_enable_o |-> status_o == 16'h0000)
    else $error("flag set while disabled");
  a_thru_no_tx: assert property ($rose(status_o[15]) || $rose(status_o[13])
    || $rose(status_o[12]) |-> mode_o != 2'h3) else $error("tx flag in through mode");
  a_rx_mode_gate: assert property ($rose(status_o[14]) || $rose(status_o[11])
    |-> mode_o inside {2'h1, 2'h2}) else $error("rx flag in wrong mode");
  a_ovf_discard: assert property (rx_byte_i && rx_buf_full_i |=> !rx_store_o)
    else $error("overflow byte stored");
  a_ovf_sets: assert property (rx_byte_i && rx_buf_full_i && module_enable_o && !wr_i
    && mode_o inside {2'h1, 2'h2} |=> status_o[11]) else $error("overflow not flagged");
  a_csum_master: assert property ($rose(status_o[10]) |-> mode_o == 2'h0)
    else $error("checksum flag outside master");
  a_sched_irq: assert property (status_irq_o |-> status_o[9])
    else $error("match pulse without flag");
  a_match_pulse: assert property ($rose(status_o[9]) |-> status_irq_o)
    else $error("match flag without pulse");
  a_sched_master: assert property ($rose(status_o[9]) |-> mode_o == 2'h0)
    else $error("match flag outside master");
  c_match: cover property ($rose(status_o[9]));
  c_overflow: cover property (rx_byte_i && rx_buf_full_i);
  c_disable: cover property ($fell(module_enable_o));
endmodule
bind lin_uart_status_flags status_flags_monitor mon (.ref_clk_i, .rst_n_i, .addr_i, .rd_i,
  .wr_i, .rdata_o, .rx_byte_i, .rx_buf_full_i, .rx_store_o, .status_o, .module_enable_o,
  .mode_o, .status_irq_o);
`default_nettype wire

//--- tb/rx_buffer_model.sv
`timescale 1ns/1ps
`default_nettype none
module rx_buffer_model #(
  parameter DEPTH = 2
) (
  input wire logic ref_clk_i, // Clock
  input wire logic rst_n_i, // Reset, active low
  input wire logic store_i, // Block stores a byte
  output logic full_o, // No room left
  output logic [3:0] count_o // Bytes held
);
  // Nothing drains, so the buffer fills for good and overflow can be provoked
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
    if (!rst_n_i)
      count_o <= 4'h0;
    else if (store_i)
      count_o <= count_o + 4'h1;
  assign full_o = (count_o == DEPTH);
endmodule
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {logic [15:0] ctl; logic [6:0] ev; logic [15:0] exp;} row_t;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, ce = 1, rxl = 1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000, d, st, rdata;
  logic [6:0] ev = 7'h00;
  logic full, store, irq, en, spirq, rxo;
  logic [1:0] mode;
  logic [3:0] cnt;
  int errors = 0, total_checks = 0, i;
  row_t rows [15] = '{'{16'h8100, 7'h00, 16'h8000}, '{16'h8303, 7'h00, 16'h0000},
    '{16'h8201, 7'h00, 16'h4000}, '{16'h8200, 7'h00, 16'h0000}, '{16'h8202, 7'h00, 16'h4000},
    '{16'h8004, 7'h01, 16'h8000}, '{16'h8100, 7'h02, 16'h0000}, '{16'h8201, 7'h04, 16'h0000},
    '{16'h8000, 7'h08, 16'h2000}, '{16'h8003, 7'h08, 16'h0000}, '{16'h8001, 7'h10, 16'h1000},
    '{16'h8003, 7'h10, 16'h0000}, '{16'h8008, 7'h20, 16'h0400}, '{16'h8000, 7'h20, 16'h0000},
    '{16'h8009, 7'h20, 16'h0000}};
  lin_uart_status_flags dut (.ref_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .auto_frame_start_i(ev[0]),
    .tx_done_i(ev[1]), .rx_done_i(ev[2]), .tx_last_sent_i(ev[3]), .rx_last_stored_i(ev[4]),
    .csum_mismatch_i(ev[5]), .rx_byte_i(ev[6]), .rx_buf_full_i(full), .rx_line_i(rxl),
    .rx_store_o(store), .status_o(st), .module_enable_o(en), .mode_o(mode),
    .status_irq_o(spirq), .irq_o(irq), .rx_line_o(rxo));
  rx_buffer_model #(.DEPTH(2)) peer (.ref_clk_i(clk), .rst_n_i(rst_n), .store_i(store),
    .full_o(full), .count_o(cnt));
  initial forever #25 clk = ~clk;
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk) addr <= a; wdata <= v; wr <= 1;
    @(posedge clk) wr <= 0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk) addr <= a; rd <= 1;
    @(posedge clk) rd <= 0;
    #1 d = rdata;
  endtask
  task automatic fire(input logic [6:0] e);
    @(posedge clk) ev <= e;
    @(posedge clk) ev <= 7'h00;
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1;
    rd_reg(8'h8C); check(d, 16'h0000);
    rd_reg(8'h80); check(d, 16'h0000);
    rd_reg(8'hFC); check(d, 16'h0000);
    // Receive pin reaches its output three edges after it changes
    @(posedge clk) rxl <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check({15'h0000, rxo}, 16'h0001);
    @(posedge clk);
    #1 check({15'h0000, rxo}, 16'h0000);
    $display("reset test done");
    for (i = 0; i < 15; i++)
    begin
      wr_reg(8'h80, rows[i].ctl);
      fire(rows[i].ev);
      rd_reg(8'h8C); check(d, rows[i].exp);
      wr_reg(8'h80, 16'h0000);
      rd_reg(8'h8C); check(d, 16'h0000);
    end
    $display("table test done");
    wr_reg(8'h80, 16'h8000);
    // A low clock enable must swallow the event
    @(posedge clk) ce <= 1'b0;
    fire(7'h08);
    @(posedge clk) ce <= 1'b1;
    rd_reg(8'h8C); check(d, 16'h0000);
    fire(7'h08);
    wr_reg(8'h8C, 16'hFFFF); rd_reg(8'h8C); check(d, 16'h2000);
    wr_reg(8'h84, 16'h2000); rd_reg(8'h8C); check(d, 16'h0000);
    wr_reg(8'h80, 16'h8002);
    repeat (3) fire(7'h40);
    rd_reg(8'h8C); check(d, 16'h0800);
    check({12'h000, cnt}, 16'h0002);
    wr_reg(8'h84, 16'h0800); rd_reg(8'h8C); check(d, 16'h0000);
    $display("write and overflow test done");
    // Every flag raised so far is still pending in the sticky interrupt status
    rd_reg(8'h94); check(d, 16'hFC00);
    fire(7'h40);
    rd_reg(8'h8C); check(d, 16'h0800);
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(8'h8C); check(d, 16'h0000);
    check({12'h000, cnt}, 16'h0000);
    $display("mid-run reset test done");
    wr_reg(8'h90, 16'h0010); wr_reg(8'h80, 16'h8010);
    for (i = 0; i < 60 && st[9] !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    if (i == 60)
      errors++;
    else
    begin
      repeat (2) @(posedge clk);
      check({15'h0000, irq}, 16'h0000);
      wr_reg(8'h98, 16'h0200); repeat (2) @(posedge clk);
      check({15'h0000, irq}, 16'h0001);
      rd_reg(8'h94); check(d, 16'h0200);
      repeat (2) @(posedge clk);
      check({15'h0000, irq}, 16'h0000);
      wr_reg(8'h84, 16'h0200); rd_reg(8'h8C); check(d, 16'h0000);
    end
    $display("scheduler test done");
    close_out();
  end
endmodule
`default_nettype wire
